// ### rtl/anmd_ctrl.sv
// anmd_ctrl: external memory bank controller, asynchronous mode D and
// multiplexed address/data accesses, with the three bank setup registers.
// assumes a same-clock register master; memory wait pin is asynchronous.
// Operation
// - access mode 3 runs mode D waveform
// - separate write timing bit selects write register
// - write timing register field layout, 27:20 reserved
// - latency and divider fields writable here; any nonzero value refuses the access
// - gap field sets chip select high time
// - mux bit, mode 0, shared timing
// - mux mode needs non SRAM memory kind
// - sync burst, wait, wrap, write-sync zero
// - access only with bank enable; reserved bits
// - control holds width, nor, wait settings
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module anmd_ctrl (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic chip_select_n_o,
	output logic addr_valid_n_o,
	output logic out_en_n_o,
	output logic wr_en_n_o,
	output logic [23:0] mem_addr_o,
	output logic [15:0] mem_data_o,
	output logic mem_data_oe_n_o,
	input wire logic [15:0] mem_data_i,
	input wire logic mem_wait_i
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] bank_control;
	logic [31:0] bank_chip_select_timing;
	logic [31:0] bank_write_timing;
	logic [23:0] acc_addr;
	logic [15:0] acc_wdata;
	logic acc_write;
	logic [15:0] rd_capture;
	logic done_flag;
	logic start_pend;
	// mux mode latched at start so a control write cannot switch pins mid-access
	logic mux_run;
	logic wait_s1, wait_s2;
	anmd_pkg::anmd_state_t state;
	anmd_pkg::anmd_state_t next_state;

	// decode
	wire sel_ctrl = (addr_i == anmd_pkg::ANMD_OFS_CTRL);
	wire sel_tmg = (addr_i == anmd_pkg::ANMD_OFS_TMG);
	wire sel_tmgwr = (addr_i == anmd_pkg::ANMD_OFS_TMGWR);
	wire sel_acc = (addr_i == anmd_pkg::ANMD_OFS_ACC);
	wire sel_stat = (addr_i == anmd_pkg::ANMD_OFS_STAT);
	wire sel_rdata = (addr_i == anmd_pkg::ANMD_OFS_RDATA);

	////////////////////////////////////////////////////////////////////////
	// configuration decode
	// timing is chosen per access; rewriting the selected timing register
	// while an access runs changes the phases still to come
	wire bank_en = bank_control[anmd_pkg::ANMD_CTL_EN];
	wire mux_en = bank_control[anmd_pkg::ANMD_CTL_MUX];
	wire sep_wr = bank_control[anmd_pkg::ANMD_CTL_SEPWR];
	wire [1:0] memory_kind = bank_control[anmd_pkg::ANMD_CTL_KIND_LO +: 2];
	wire wait_in_async_enable = bank_control[anmd_pkg::ANMD_CTL_AWAIT];
	wire wait_polarity = bank_control[anmd_pkg::ANMD_CTL_WPOL];
	wire [1:0] rd_mode = bank_chip_select_timing[anmd_pkg::ANMD_TMG_MODE_LO +: 2];
	// pick timing set: write set only for writes with separate timing
	wire use_wr_tmg = acc_write && sep_wr && !mux_en;
	wire [31:0] tmg = use_wr_tmg ? bank_write_timing : bank_chip_select_timing;
	wire [1:0] cur_mode = tmg[anmd_pkg::ANMD_TMG_MODE_LO +: 2];
	wire [3:0] setup_len = tmg[anmd_pkg::ANMD_TMG_SETUP_LO +: 4];
	wire [3:0] hold_len = tmg[anmd_pkg::ANMD_TMG_HOLD_LO +: 4];
	wire [7:0] data_len = tmg[anmd_pkg::ANMD_TMG_DATA_LO +: 8];
	wire [3:0] gap_len = tmg[anmd_pkg::ANMD_TMG_GAP_LO +: 4];
	wire [3:0] sync_data_latency = bank_chip_select_timing[anmd_pkg::ANMD_TMG_LAT_LO +: 4];
	wire [3:0] memclk_divider = bank_chip_select_timing[anmd_pkg::ANMD_TMG_DIV_LO +: 4];
	// sync features that must stay off for these asynchronous modes
	wire sync_bits = bank_control[anmd_pkg::ANMD_CTL_SBURST]
		| bank_control[anmd_pkg::ANMD_CTL_SWAIT]
		| bank_control[anmd_pkg::ANMD_CTL_WRAP]
		| bank_control[anmd_pkg::ANMD_CTL_WSYNC];
	wire lat_div_set = (sync_data_latency != 4'h0) || (memclk_divider != 4'h0);
	wire mode_d_ok = !mux_en && (cur_mode == anmd_pkg::ANMD_MODE_D);
	wire mux_ok = mux_en && (rd_mode == anmd_pkg::ANMD_MODE_A) && !sep_wr
		&& (memory_kind != anmd_pkg::ANMD_KIND_SRAM);
	wire cfg_ok = (mode_d_ok || mux_ok) && !sync_bits && !lat_div_set;

	////////////////////////////////////////////////////////////////////////
	// pin is asynchronous to clk_i, hence two flops before any logic
	// memory wait: two flops, then polarity; stretches the data phase
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wait_s1 <= 1'b0;
			wait_s2 <= 1'b0;
		end else begin
			wait_s1 <= mem_wait_i;
			wait_s2 <= wait_s1;
		end
	end
	wire wait_act = wait_in_async_enable && (wait_s2 == wait_polarity);

	////////////////////////////////////////////////////////////////////////
	// phase timer
	// one shared counter; each phase reloads it, so phases never overlap
	logic load;
	logic [7:0] load_len;
	logic last;
	anmd_phase_cnt u_cnt (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.load_i(load),
		.len_i(load_len),
		.last_o(last)
	);

	// a queued access may start from idle or straight off the last gap cycle
	wire go = start_pend && bank_en && cfg_ok;

	// sequencing: setup+1, hold+1, data+1, gap cycles with chip select high
	// wait stretches only the data phase, where the memory drives its answer
	always_comb begin
		next_state = state;
		load = 1'b0;
		load_len = 8'h00;
		unique case (state)
			anmd_pkg::ANMD_IDLE: begin
				if (go) begin
					next_state = anmd_pkg::ANMD_SETUP;
					load = 1'b1;
					load_len = {4'h0, setup_len};
				end
			end
			anmd_pkg::ANMD_SETUP: begin
				if (last) begin
					next_state = anmd_pkg::ANMD_HOLD;
					load = 1'b1;
					load_len = {4'h0, hold_len};
				end
			end
			anmd_pkg::ANMD_HOLD: begin
				if (last) begin
					next_state = anmd_pkg::ANMD_DATA;
					load = 1'b1;
					load_len = data_len;
				end
			end
			anmd_pkg::ANMD_DATA: begin
				if (last && !wait_act) begin
					if (gap_len != 4'h0) begin
						next_state = anmd_pkg::ANMD_GAP;
						load = 1'b1;
						load_len = {4'h0, gap_len} - 8'h01;
					end else begin
						next_state = anmd_pkg::ANMD_IDLE;
					end
				end
			end
			anmd_pkg::ANMD_GAP: begin
				if (last && go) begin
					next_state = anmd_pkg::ANMD_SETUP;
					load = 1'b1;
					load_len = {4'h0, setup_len};
				end else if (last) begin
					next_state = anmd_pkg::ANMD_IDLE;
				end
			end
			default: begin
				next_state = anmd_pkg::ANMD_IDLE;
			end
		endcase
	end

	// end of data phase: capture, done flag and gap start
	wire data_end = (state == anmd_pkg::ANMD_DATA) && last && !wait_act;

	// state register; sync reset returns to idle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= anmd_pkg::ANMD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes; a start refused by config stays pending until fixed
	// access and data registers refuse writes while an access is queued
	wire start_req = wr_i && sel_acc;
	wire started = (state != anmd_pkg::ANMD_SETUP) && (next_state == anmd_pkg::ANMD_SETUP);
	// queueing during the gap lets the gap field alone set chip select high time
	wire idle = ((state == anmd_pkg::ANMD_IDLE) || (state == anmd_pkg::ANMD_GAP))
		&& !start_pend;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bank_control <= anmd_pkg::ANMD_CTL_FORCE;
			bank_chip_select_timing <= 32'h0000_0000;
			bank_write_timing <= 32'h0000_0000;
			acc_addr <= 24'h00_0000;
			acc_wdata <= 16'h0000;
			acc_write <= 1'b0;
			start_pend <= 1'b0;
			mux_run <= 1'b0;
		end else begin
			if (wr_i && sel_ctrl) begin
				bank_control <= (wdata_i & anmd_pkg::ANMD_CTL_WMASK)
					| anmd_pkg::ANMD_CTL_FORCE;
			end
			if (wr_i && sel_tmg) begin
				bank_chip_select_timing <= wdata_i & anmd_pkg::ANMD_TMG_WMASK;
			end
			if (wr_i && sel_tmgwr) begin
				bank_write_timing <= wdata_i & anmd_pkg::ANMD_TMGWR_WMASK;
			end
			if (start_req && idle) begin
				acc_addr <= wdata_i[anmd_pkg::ANMD_ADDR_W-1:0];
				acc_write <= wdata_i[anmd_pkg::ANMD_ACC_WR];
				start_pend <= 1'b1;
			end else if (started) begin
				start_pend <= 1'b0;
				mux_run <= mux_en;
			end
			if (wr_i && sel_rdata && idle) begin
				acc_wdata <= wdata_i[anmd_pkg::ANMD_DATA_W-1:0];
			end
		end
	end

	// read capture and done flag; a new start clears done, completion sets it
	// memory data sampled on the last data cycle, after oe_n has long been low
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_capture <= 16'h0000;
			done_flag <= 1'b0;
		end else begin
			if (data_end && !acc_write) begin
				rd_capture <= mem_data_i;
			end
			if (data_end) begin
				done_flag <= 1'b1;
			end else if (start_req && idle) begin
				done_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero
	// registered so the answer stands in the cycle after rd_i and then holds
	wire [31:0] stat_word = {27'h000_0000, mux_en, mode_d_ok, !cfg_ok, done_flag, !idle};
	wire [31:0] rd_mux = sel_ctrl ? bank_control :
		sel_tmg ? bank_chip_select_timing :
		sel_tmgwr ? bank_write_timing :
		sel_acc ? {acc_write, 7'h00, acc_addr} :
		sel_stat ? stat_word :
		sel_rdata ? {16'h0000, rd_capture} : 32'h0000_0000;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive, all registered
	// pins come from next_state through flops, so strobes never glitch
	wire active = (state == anmd_pkg::ANMD_SETUP) || (state == anmd_pkg::ANMD_HOLD)
		|| (state == anmd_pkg::ANMD_DATA);
	wire nxt_active = (next_state == anmd_pkg::ANMD_SETUP)
		|| (next_state == anmd_pkg::ANMD_HOLD) || (next_state == anmd_pkg::ANMD_DATA);
	wire nxt_setup = (next_state == anmd_pkg::ANMD_SETUP);
	wire nxt_data = (next_state == anmd_pkg::ANMD_DATA);
	// pins follow the mode latched at start, or the live bit on the start edge
	wire mux_pins = started ? mux_en : mux_run;
	// mode D drops read strobe after setup; write strobe only in data phase
	wire nxt_oe = nxt_active && !acc_write && (mux_pins ? nxt_data : !nxt_setup);
	wire nxt_we = nxt_data && acc_write;
	// mux: low address sits on data lines during setup and hold
	wire nxt_drv_addr = mux_pins && nxt_active && !nxt_data;
	wire nxt_drv_data = nxt_data && acc_write;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			chip_select_n_o <= 1'b1;
			addr_valid_n_o <= 1'b1;
			out_en_n_o <= 1'b1;
			wr_en_n_o <= 1'b1;
			mem_addr_o <= 24'h00_0000;
			mem_data_o <= 16'h0000;
			mem_data_oe_n_o <= 1'b1;
		end else begin
			chip_select_n_o <= !nxt_active;
			addr_valid_n_o <= !(nxt_setup && mux_pins);
			out_en_n_o <= !nxt_oe;
			wr_en_n_o <= !nxt_we;
			if (nxt_active && !active) begin
				mem_addr_o <= acc_addr;
			end
			mem_data_o <= nxt_drv_addr ? acc_addr[anmd_pkg::ANMD_DATA_W-1:0] : acc_wdata;
			mem_data_oe_n_o <= !(nxt_drv_addr || nxt_drv_data);
		end
	end
endmodule

// ### rtl/anmd_phase_cnt.sv
// anmd_phase_cnt: loadable down counter that marks the last cycle of a phase.
// assumes the owner loads it on every phase change with length minus one.
`timescale 1ns/10ps
module anmd_phase_cnt (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic load_i,
	input wire logic [7:0] len_i,
	output logic last_o
);
	logic [7:0] cnt;

	// count down; load wins so a phase always starts from its full length
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt <= 8'h00;
		end else if (load_i) begin
			cnt <= len_i;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
	end

	assign last_o = (cnt == 8'h00); // length n+1 cycles from load of n
endmodule

// ### rtl/anmd_pkg.sv
// anmd_pkg: register offsets, field positions and timing constants for the
// asynchronous mode D / multiplexed external memory bank controller.
// assumes a plain register port with byte offsets and a 100 MHz clock.
package anmd_pkg;
	// register byte offsets
	localparam logic [7:0] ANMD_OFS_CTRL = 8'h00;
	localparam logic [7:0] ANMD_OFS_TMG = 8'h04;
	localparam logic [7:0] ANMD_OFS_TMGWR = 8'h08;
	localparam logic [7:0] ANMD_OFS_ACC = 8'h0C;
	localparam logic [7:0] ANMD_OFS_STAT = 8'h10;
	localparam logic [7:0] ANMD_OFS_RDATA = 8'h14;

	// control register fields
	localparam int ANMD_CTL_EN = 0;
	localparam int ANMD_CTL_MUX = 1;
	localparam int ANMD_CTL_KIND_LO = 2;
	localparam int ANMD_CTL_BW_LO = 4;
	localparam int ANMD_CTL_NOR = 6;
	localparam int ANMD_CTL_RSV7 = 7;
	localparam int ANMD_CTL_SBURST = 8;
	localparam int ANMD_CTL_WPOL = 9;
	localparam int ANMD_CTL_WRAP = 10;
	localparam int ANMD_CTL_SWAIT = 13;
	localparam int ANMD_CTL_SEPWR = 14;
	localparam int ANMD_CTL_AWAIT = 15;
	localparam int ANMD_CTL_WSYNC = 19;
	// writable control bits 19:0, bit 7 always reads one, 31:20 zero
	localparam logic [31:0] ANMD_CTL_WMASK = 32'h000F_FF7F;
	localparam logic [31:0] ANMD_CTL_FORCE = 32'h0000_0080;
	// timing register: 29:28 mode, 27:24 latency, 23:20 divider, rest timing
	localparam logic [31:0] ANMD_TMG_WMASK = 32'h3FFF_FFFF;
	localparam logic [31:0] ANMD_TMGWR_WMASK = 32'h300F_FFFF;
	localparam int ANMD_TMG_MODE_LO = 28;
	localparam int ANMD_TMG_GAP_LO = 16;
	localparam int ANMD_TMG_DATA_LO = 8;
	localparam int ANMD_TMG_HOLD_LO = 4;
	localparam int ANMD_TMG_SETUP_LO = 0;
	localparam int ANMD_TMG_LAT_LO = 24;
	localparam int ANMD_TMG_DIV_LO = 20;
	localparam logic [1:0] ANMD_MODE_D = 2'h3;
	localparam logic [1:0] ANMD_MODE_A = 2'h0;
	localparam logic [1:0] ANMD_KIND_SRAM = 2'h0;

	// access register: bit 31 write, 23:0 address; write data in 15:0 of the read data register
	localparam int ANMD_ACC_WR = 31;
	localparam int ANMD_ADDR_W = 24;
	localparam int ANMD_DATA_W = 16;

	// status bits
	localparam int ANMD_ST_BUSY = 0;
	localparam int ANMD_ST_DONE = 1;
	localparam int ANMD_ST_CFGERR = 2;
	localparam int ANMD_ST_MODED = 3;
	localparam int ANMD_ST_MUX = 4;

	typedef enum logic [2:0] {
		ANMD_IDLE = 3'b000,
		ANMD_SETUP = 3'b001,
		ANMD_HOLD = 3'b010,
		ANMD_DATA = 3'b011,
		ANMD_GAP = 3'b100
	} anmd_state_t;
endpackage

// ### test/anmd_ctrl_sva.sv
// anmd_ctrl_sva: pin and register checks on the bank controller.
// assumes binding to anmd_ctrl, one clock, sync reset.
`timescale 1ns/10ps
module anmd_ctrl_sva (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic chip_select_n_o,
	input wire logic addr_valid_n_o,
	input wire logic out_en_n_o,
	input wire logic wr_en_n_o,
	input wire logic [23:0] mem_addr_o,
	input wire logic [15:0] mem_data_o,
	input wire logic mem_data_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	//////////////////////////////////////////////////////////////////
	// phase shape: three phases of at least one cycle each
	AST_CS_MIN: assert property ($fell(chip_select_n_o) |-> !chip_select_n_o[*3])
		else $error("chip select low too short");
	AST_CS_GAP: assert property ($rose(chip_select_n_o) |-> out_en_n_o && wr_en_n_o && mem_data_oe_n_o)
		else $error("bus not released at access end");
	AST_IDLE_PINS: assert property (chip_select_n_o |-> out_en_n_o && wr_en_n_o && addr_valid_n_o)
		else $error("strobe outside chip select");
	AST_ADDR_STABLE: assert property (!chip_select_n_o && !$past(chip_select_n_o) |-> $stable(mem_addr_o))
		else $error("address moved in access");
	// bus ownership: never fight the memory
	AST_WE_DRIVE: assert property (!wr_en_n_o |-> !mem_data_oe_n_o && out_en_n_o)
		else $error("write without driving data");
	AST_OE_FREE: assert property (!out_en_n_o |-> mem_data_oe_n_o)
		else $error("driving data during read");
	AST_MUX_ADDR: assert property (!addr_valid_n_o |-> !mem_data_oe_n_o && mem_data_o == mem_addr_o[15:0])
		else $error("low address not on data lines");
	// reserved bits as read back, and read data holding between reads
	AST_CTRL_RSV: assert property (rd_i && addr_i == anmd_pkg::ANMD_OFS_CTRL |=> rdata_o[7] && rdata_o[31:20] == 12'h000)
		else $error("control reserved bits wrong");
	AST_WR_RSV: assert property (rd_i && addr_i == anmd_pkg::ANMD_OFS_TMGWR |=> rdata_o[31:30] == 2'h0 && rdata_o[27:20] == 8'h00)
		else $error("write timing reserved bits wrong");
	AST_RDATA_HOLD: assert property (!$past(rd_i) |-> $stable(rdata_o))
		else $error("read data moved without read");
	cover property ($fell(addr_valid_n_o));
	cover property ($fell(wr_en_n_o));
	cover property ($fell(out_en_n_o));
	cover property ($rose(chip_select_n_o) ##5 $fell(chip_select_n_o));
endmodule

// ### test/anmd_ctrl_tb.sv
// anmd_ctrl_tb: register, mode D and multiplexed access scenarios.
// assumes anmd_mem_model as memory; wait pin driven by the bench.
`timescale 1ns/10ps
module anmd_ctrl_tb;
	logic clk_i = 0;
	logic srst_i = 1;
	logic wr_i = 0;
	logic rd_i = 0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic [31:0] rdata_o, s;
	logic cs_n, adv_n, oe_n, we_n, drv_n;
	logic [23:0] ma;
	logic [15:0] md_o, md_i;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	logic wt = 1'b0;
	int hi_run = 0;
	int hi_last = 0;

	//////////////////////////////////////////////////////////////////
	always #5 clk_i = ~clk_i;
	// length of the last chip select high stretch, seen mid-cycle
	always @(negedge clk_i) begin
		if (cs_n === 1'b1) begin
			hi_run++;
		end else begin
			if (hi_run > 0) hi_last = hi_run;
			hi_run = 0;
		end
	end
	anmd_ctrl dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chip_select_n_o(cs_n),
		.addr_valid_n_o(adv_n), .out_en_n_o(oe_n), .wr_en_n_o(we_n), .mem_addr_o(ma),
		.mem_data_o(md_o), .mem_data_oe_n_o(drv_n), .mem_data_i(md_i), .mem_wait_i(wt));
	anmd_mem_model mem (.clk_i(clk_i), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
		.adv_n_i(adv_n), .drv_n_i(drv_n), .addr_i(ma), .wd_i(md_o), .rd_o(md_i));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle strobes, a free edge after each so none is set twice at once
	task wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge clk_i);
	endtask
	// chip select low cycles, sampled mid-cycle; 0 if it never falls
	task meas(output int c);
		int k;
		k = 0;
		c = 0;
		do @(negedge clk_i); while (cs_n && ++k < 60);
		while (!cs_n && c < 300) begin
			c++;
			@(negedge clk_i);
		end
		@(posedge clk_i);
	endtask
	task t_regs;
		logic [31:0] rv [4] = '{32'h0000_0080, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
		logic [31:0] fv [4] = '{32'h000F_FFFF, 32'h3FFF_FFFF, 32'h300F_FFFF, 32'h0000_0000};
		for (int i = 0; i < 4; i++) begin
			rd(8'(i == 3 ? 24 : i * 4), s);
			chk(s, rv[i]);
			wr(8'(i == 3 ? 24 : i * 4), 32'hFFFF_FFFF);
			rd(8'(i == 3 ? 24 : i * 4), s);
			chk(s, fv[i]);
		end
	endtask
	task t_mode_d;
		wr(8'h00, 32'h0000_00D9);
		wr(8'h04, 32'h3002_0201);
		wr(8'h0C, 32'h0000_0005);
		meas(n);
		chk(n, 6);
		rd(8'h14, s);
		chk(32'(s[15:0]), 32'h0000_A505);
		rd(8'h10, s);
		chk(32'(s[3:1]), 32'h0000_0005);
		wr(8'h00, 32'h0000_40D9);
		wr(8'h08, 32'h3000_0500);
		wr(8'h14, 32'h0000_1234);
		wr(8'h0C, 32'h8000_0005);
		meas(n);
		chk(n, 8);
		chk(32'(mem.mem[5]), 32'h0000_1234);
		wr(8'h0C, 32'h0000_0005);
		meas(n);
		chk(n, 6);
		rd(8'h14, s);
		chk(32'(s[15:0]), 32'h0000_1234);
	endtask
	// active wait pin stalls the data phase; a queued access then starts
	// straight off a five-cycle gap
	task t_wait_gap;
		wt <= 1'b1;
		wr(8'h00, 32'h0000_82D9);
		wr(8'h04, 32'h3005_0000);
		wr(8'h0C, 32'h0000_0007);
		repeat (4) @(posedge clk_i);
		wt <= 1'b0;
		meas(n);
		chk(n, 3);
		wr(8'h0C, 32'h0000_0006);
		meas(n);
		chk(n, 3);
		chk(hi_last, 5);
		rd(8'h14, s);
		chk(32'(s[15:0]), 32'h0000_A506);
	endtask
	// illegal settings keep the access pending until fixed
	task t_mux;
		logic [31:0] bad [5] = '{32'h0000_0093, 32'h0000_0197, 32'h0000_0497,
			32'h0000_2097, 32'h0008_0097};
		wr(8'h04, 32'h0001_0111);
		wr(8'h0C, 32'h0000_0003);
		for (int i = 0; i < 5; i++) begin
			wr(8'h00, bad[i]);
			rd(8'h10, s);
			chk(32'(s[2]), 32'h0000_0001);
		end
		wr(8'h04, 32'h0101_0111);
		wr(8'h00, 32'h0000_0097);
		rd(8'h10, s);
		chk(32'(s[2]), 32'h0000_0001);
		wr(8'h00, 32'h0000_0096);
		wr(8'h04, 32'h0001_0111);
		meas(n);
		chk(n, 0);
		wr(8'h00, 32'h0000_0097);
		meas(n);
		chk(n, 6);
		rd(8'h14, s);
		chk(32'(s[15:0]), 32'h0000_A503);
		rd(8'h10, s);
		chk(32'(s[4]), 32'h0000_0001);
	endtask
	task finish_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////
	// main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_mode_d;
		t_wait_gap;
		t_mux;
		finish_test;
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test;
		end
	end
endmodule

bind anmd_ctrl anmd_ctrl_sva u_sva (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .chip_select_n_o(chip_select_n_o),
	.addr_valid_n_o(addr_valid_n_o), .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o),
	.mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_data_oe_n_o(mem_data_oe_n_o));

// ### test/anmd_mem_model.sv
// anmd_mem_model: sixteen-word async memory behind the bank pins.
// assumes pins from anmd_ctrl; mux address taken off the data lines.
`timescale 1ns/10ps
module anmd_mem_model (
	input wire logic clk_i,
	input wire logic cs_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic adv_n_i,
	input wire logic drv_n_i,
	input wire logic [23:0] addr_i,
	input wire logic [15:0] wd_i,
	output logic [15:0] rd_o
);
	logic [15:0] mem [16];
	logic [15:0] last;
	logic [3:0] mux_a;
	logic mux_f = 1'b0;
	wire [3:0] a = mux_f ? mux_a : addr_i[3:0];

	//////////////////////////////////////////////////////////////////
	// released lines show the inverse, so a stale value never passes
	assign rd_o = (!cs_n_i && !oe_n_i) ? mem[a] : ~last;
	initial for (int i = 0; i < 16; i++) mem[i] = 16'hA500 + 16'(i);
	// latch low address while the valid strobe is low
	always @(posedge clk_i) begin
		last <= rd_o;
		if (!adv_n_i && !drv_n_i) begin
			mux_a <= wd_i[3:0];
			mux_f <= 1'b1;
		end else if (cs_n_i) begin
			mux_f <= 1'b0;
		end
		if (!cs_n_i && !we_n_i && !drv_n_i) mem[a] <= wd_i;
	end
endmodule
